// ==== rtl/stcr_regs.sv ====
// Configuration bank for a display-link receiver: sync timing, divisor,
// training score overrides, payload view, CRC values, identification flags.
// Assumes a single-cycle register port and one clock for bank and generator.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Line sync output is a fixed-length active-high pulse.
// - Line sync stays high exactly pulse-width field cycles.
// - Front-gap field cycles separate last active pixel and line sync.
// - Line sync timing register resets to 0x0F0F.
// - Frame sync lasts frame-width field cycles; width resets to 63.
// - Frame sync output is an active-high pulse.
// - Bit 31 selects programmed 15-bit first pattern score.
// - Bit 31 selects programmed 13-bit later patterns score.
// - Read-only view mirrors payload tag, start slot, slot count.
// - CRC control bit 5 enables CRC; values come from software.
// - Red, green, blue CRC registers feed per-colour CRC results.
// - Video ident bit 0 advertises local video identification support.
// - Audio ident bit 0 advertises local audio identification support.
module stcr_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  input wire logic [14:0] OWN_FIRST_SCORE_IN,
  input wire logic [12:0] OWN_LATER_SCORE_IN,
  input wire logic [5:0] PAYLOAD_TAG_IN,
  input wire logic [5:0] START_SLOT_IN,
  input wire logic [5:0] SLOT_COUNT_IN,
  output logic [14:0] FIRST_SCORE_OUT,
  output logic [12:0] LATER_SCORE_OUT,
  output logic [7:0] TWO_WIRE_DIV_OUT,
  output logic CRC_EN_OUT,
  output logic [3:0] CRC_CHANGE_COUNT_OUT,
  output logic [31:0] CRC_RED_OUT,
  output logic [31:0] CRC_GREEN_OUT,
  output logic [31:0] CRC_BLUE_OUT,
  output logic VIDEO_IDENT_OUT,
  output logic AUDIO_IDENT_OUT,
  output logic LINE_SYNC_OUT,
  output logic FRAME_SYNC_OUT,
  output logic DATA_ENABLE_OUT
);
  // Only the 12-bit byte address map is decoded
  if (ADDR_W != 12) begin : g_addr_w_chk
    $error("ADDR_W must be 12");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] line_sync_r;
  logic [15:0] frame_sync_r;
  logic [7:0] two_wire_div_r;
  logic [31:0] first_score_r;
  logic [31:0] later_score_r;
  logic [5:0] crc_ctrl_r;
  logic [31:0] crc_red_r;
  logic [31:0] crc_green_r;
  logic [31:0] crc_blue_r;
  logic video_ident_r;
  logic audio_ident_r;
  logic [15:0] active_len_r;
  logic [15:0] lines_r;
  logic [7:0] back_gap_r;
  logic [31:0] rdata_r;
  stcr_pkg::stcr_bus_s bus;

  // Bundle the request
  assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // Address decode for writes
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_line = bus.wr && hit(bus.addr, stcr_pkg::OFS_LINE_SYNC);
  wire wr_frame = bus.wr && hit(bus.addr, stcr_pkg::OFS_FRAME_SYNC);
  wire wr_div = bus.wr && hit(bus.addr, stcr_pkg::OFS_TWO_WIRE_DIV);
  wire wr_first = bus.wr && hit(bus.addr, stcr_pkg::OFS_FIRST_SCORE);
  wire wr_later = bus.wr && hit(bus.addr, stcr_pkg::OFS_LATER_SCORE);
  wire wr_crcc = bus.wr && hit(bus.addr, stcr_pkg::OFS_CRC_CTRL);
  wire wr_red = bus.wr && hit(bus.addr, stcr_pkg::OFS_CRC_RED);
  wire wr_green = bus.wr && hit(bus.addr, stcr_pkg::OFS_CRC_GREEN);
  wire wr_blue = bus.wr && hit(bus.addr, stcr_pkg::OFS_CRC_BLUE);
  wire wr_vid = bus.wr && hit(bus.addr, stcr_pkg::OFS_VIDEO_IDENT);
  wire wr_aud = bus.wr && hit(bus.addr, stcr_pkg::OFS_AUDIO_IDENT);
  wire wr_tctl = bus.wr && hit(bus.addr, stcr_pkg::OFS_TIMING_CTRL);

  // Writes keep only defined bits
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      line_sync_r <= stcr_pkg::RST_LINE_SYNC;
      frame_sync_r <= stcr_pkg::RST_FRAME_SYNC;
      two_wire_div_r <= 8'h00;
      first_score_r <= 32'h0000_0000;
      later_score_r <= 32'h0000_0000;
      crc_ctrl_r <= 6'h00;
      crc_red_r <= 32'h0000_0000;
      crc_green_r <= 32'h0000_0000;
      crc_blue_r <= 32'h0000_0000;
      video_ident_r <= 1'b0;
      audio_ident_r <= 1'b0;
      active_len_r <= stcr_pkg::RST_ACTIVE_LEN;
      lines_r <= stcr_pkg::RST_LINES;
      back_gap_r <= stcr_pkg::RST_BACK_GAP;
    end else begin
      if (wr_line) line_sync_r <= bus.wdata[15:0];
      if (wr_frame) frame_sync_r <= bus.wdata[15:0];
      if (wr_div) two_wire_div_r <= bus.wdata[7:0];
      if (wr_first) first_score_r <= {bus.wdata[31], 16'h0000, bus.wdata[14:0]};
      if (wr_later) later_score_r <= {bus.wdata[31], 18'h00000, bus.wdata[12:0]};
      if (wr_crcc) crc_ctrl_r <= {bus.wdata[5], 1'b0, bus.wdata[3:0]};
      if (wr_red) crc_red_r <= bus.wdata;
      if (wr_green) crc_green_r <= bus.wdata;
      if (wr_blue) crc_blue_r <= bus.wdata;
      if (wr_vid) video_ident_r <= bus.wdata[0];
      if (wr_aud) audio_ident_r <= bus.wdata[0];
      if (wr_tctl) begin
        active_len_r <= bus.wdata[15:0];
        lines_r <= bus.wdata[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  wire [31:0] payload_view = {10'h000, SLOT_COUNT_IN, 2'h0, START_SLOT_IN, 2'h0, PAYLOAD_TAG_IN};

  always_comb begin
    case (bus.addr)
      stcr_pkg::OFS_LINE_SYNC: rd_mux = {16'h0000, line_sync_r};
      stcr_pkg::OFS_FRAME_SYNC: rd_mux = {16'h0000, frame_sync_r};
      stcr_pkg::OFS_TWO_WIRE_DIV: rd_mux = {24'h000000, two_wire_div_r};
      stcr_pkg::OFS_FIRST_SCORE: rd_mux = first_score_r;
      stcr_pkg::OFS_LATER_SCORE: rd_mux = later_score_r;
      stcr_pkg::OFS_PAYLOAD_VIEW: rd_mux = payload_view;
      stcr_pkg::OFS_CRC_CTRL: rd_mux = {26'h0000000, crc_ctrl_r};
      stcr_pkg::OFS_CRC_RED: rd_mux = crc_red_r;
      stcr_pkg::OFS_CRC_GREEN: rd_mux = crc_green_r;
      stcr_pkg::OFS_CRC_BLUE: rd_mux = crc_blue_r;
      stcr_pkg::OFS_VIDEO_IDENT: rd_mux = {31'h00000000, video_ident_r};
      stcr_pkg::OFS_AUDIO_IDENT: rd_mux = {31'h00000000, audio_ident_r};
      stcr_pkg::OFS_TIMING_CTRL: rd_mux = {lines_r, active_len_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) rdata_r <= 32'h0000_0000;
    else rdata_r <= bus.rd ? rd_mux : 32'h0000_0000;
  end
  assign RDATA_OUT = rdata_r;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Score selection between programmed and own values
  assign FIRST_SCORE_OUT = first_score_r[stcr_pkg::OVERRIDE_BIT] ? first_score_r[14:0] : OWN_FIRST_SCORE_IN;
  assign LATER_SCORE_OUT = later_score_r[stcr_pkg::OVERRIDE_BIT] ? later_score_r[12:0] : OWN_LATER_SCORE_IN;
  assign TWO_WIRE_DIV_OUT = two_wire_div_r;
  assign CRC_EN_OUT = crc_ctrl_r[stcr_pkg::CRC_EN_BIT];
  assign CRC_CHANGE_COUNT_OUT = crc_ctrl_r[3:0];
  assign CRC_RED_OUT = crc_red_r;
  assign CRC_GREEN_OUT = crc_green_r;
  assign CRC_BLUE_OUT = crc_blue_r;
  assign VIDEO_IDENT_OUT = video_ident_r;
  assign AUDIO_IDENT_OUT = audio_ident_r;

  // ----------------------------------------------------------------
  // Timing generator
  // ----------------------------------------------------------------
  stcr_pkg::stcr_line_e phase_r, phase_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] line_r, line_nxt;
  logic [15:0] fcnt_r, fcnt_nxt;
  logic hs_r, fs_r, de_r;
  wire [7:0] front_gap = line_sync_r[15:8];
  wire [7:0] pulse_w = line_sync_r[7:0];
  wire frame_start = (phase_r == stcr_pkg::ST_ACTIVE) && (cnt_r == 16'h0000) && (line_r == 16'h0000);
  // Phase entered after the front gap; a zero pulse width skips the sync phase
  stcr_pkg::stcr_line_e after_gap;
  assign after_gap = (pulse_w != 8'h00) ? stcr_pkg::ST_SYNC : stcr_pkg::ST_BACK;

  // Line phase sequencing; a zero-length front gap or sync phase is skipped
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r + 16'h0001;
    line_nxt = line_r;
    case (phase_r)
      stcr_pkg::ST_ACTIVE: begin
        if (cnt_r + 16'h0001 >= active_len_r) begin
          cnt_nxt = 16'h0000;
          phase_nxt = (front_gap != 8'h00) ? stcr_pkg::ST_FRONT : after_gap;
        end
      end
      stcr_pkg::ST_FRONT: begin
        if (cnt_r + 16'h0001 >= {8'h00, front_gap}) begin
          cnt_nxt = 16'h0000;
          phase_nxt = after_gap;
        end
      end
      stcr_pkg::ST_SYNC: begin
        if (cnt_r + 16'h0001 >= {8'h00, pulse_w}) begin
          cnt_nxt = 16'h0000;
          phase_nxt = stcr_pkg::ST_BACK;
        end
      end
      stcr_pkg::ST_BACK: begin
        if (cnt_r + 16'h0001 >= {8'h00, back_gap_r}) begin
          cnt_nxt = 16'h0000;
          phase_nxt = stcr_pkg::ST_ACTIVE;
          line_nxt = (line_r + 16'h0001 >= lines_r) ? 16'h0000 : line_r + 16'h0001;
        end
      end
      default: begin
        cnt_nxt = 16'h0000;
        phase_nxt = stcr_pkg::ST_ACTIVE;
      end
    endcase
  end

  // Frame sync count, loaded at the start of each frame
  always_comb begin
    fcnt_nxt = (fcnt_r != 16'h0000) ? fcnt_r - 16'h0001 : 16'h0000;
    if (frame_start) fcnt_nxt = frame_sync_r;
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      phase_r <= stcr_pkg::ST_ACTIVE;
      cnt_r <= 16'h0000;
      line_r <= 16'h0000;
      fcnt_r <= 16'h0000;
      hs_r <= 1'b0;
      fs_r <= 1'b0;
      de_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      line_r <= line_nxt;
      fcnt_r <= fcnt_nxt;
      hs_r <= (phase_nxt == stcr_pkg::ST_SYNC);
      fs_r <= (fcnt_nxt != 16'h0000);
      de_r <= (phase_nxt == stcr_pkg::ST_ACTIVE);
    end
  end

  assign LINE_SYNC_OUT = hs_r;
  assign FRAME_SYNC_OUT = fs_r;
  assign DATA_ENABLE_OUT = de_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Pulse lengths as seen on the outputs; the dirty flag marks a line
  // pulse whose width field was rewritten while it ran
  logic [7:0] hs_len_r;
  logic hs_dirty_r;
  logic [15:0] fs_len_r;
  logic [15:0] fs_w_r;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      hs_len_r <= 8'h00;
      hs_dirty_r <= 1'b0;
      fs_len_r <= 16'h0000;
      fs_w_r <= 16'h0000;
    end else begin
      hs_len_r <= hs_r ? hs_len_r + 8'h01 : 8'h00;
      hs_dirty_r <= hs_r && (hs_dirty_r || wr_line);
      fs_len_r <= (frame_start || !fs_r) ? 16'h0000 : fs_len_r + 16'h0001;
      fs_w_r <= frame_start ? frame_sync_r : fs_w_r;
    end
  end

  // Edges of the timing outputs
  sequence de_fall;
    de_r ##1 !de_r;
  endsequence
  sequence hs_rise;
    !hs_r ##1 hs_r;
  endsequence

  line_sync_len_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $fell(hs_r) && !hs_dirty_r |-> hs_len_r == pulse_w)
    else $error("line sync width wrong");
  line_sync_end_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $fell(hs_r) |-> $past(phase_r) == stcr_pkg::ST_SYNC && phase_r == stcr_pkg::ST_BACK)
    else $error("line sync ended outside sync phase");
  front_gap_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    de_fall ##0 (front_gap == 8'h02 && pulse_w != 8'h00 && !wr_line && !$past(wr_line))
    |-> !hs_r ##1 !hs_r ##1 hs_r)
    else $error("front gap length wrong");
  line_reset_a: assert property (@(posedge CLK_IN)
    $fell(SYS_RST_IN) |-> line_sync_r == stcr_pkg::RST_LINE_SYNC && frame_sync_r == stcr_pkg::RST_FRAME_SYNC)
    else $error("sync reset value wrong");
  frame_sync_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    frame_start && !wr_frame && !SYS_RST_IN |=> fs_r == (frame_sync_r != 16'h0000))
    else $error("frame sync not started");
  frame_high_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $rose(fs_r) |-> $past(frame_start))
    else $error("frame sync rose outside frame start");
  first_score_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    first_score_r[31] |-> FIRST_SCORE_OUT == first_score_r[14:0])
    else $error("first score override ignored");
  later_score_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !later_score_r[31] |-> LATER_SCORE_OUT == OWN_LATER_SCORE_IN)
    else $error("later score override wrong");
  read_zero_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !bus.rd |=> RDATA_OUT == 32'h0000_0000)
    else $error("read data outside read slot");
  crc_write_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_crcc |=> CRC_EN_OUT == $past(WDATA_IN[5]))
    else $error("crc enable not written");
  ident_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_vid |=> VIDEO_IDENT_OUT == $past(WDATA_IN[0]))
    else $error("video ident not written");
  audio_ident_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_aud |=> AUDIO_IDENT_OUT == $past(WDATA_IN[0]))
    else $error("audio ident not written");
  payload_view_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    bus.rd && bus.addr == stcr_pkg::OFS_PAYLOAD_VIEW |=> RDATA_OUT[13:8] == $past(START_SLOT_IN))
    else $error("payload view wrong");
  // Frame sync length matches the width latched at frame start
  frame_len_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $fell(fs_r) |-> fs_len_r == fs_w_r)
    else $error("frame sync length wrong");
  frame_write_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_frame |=> frame_sync_r == $past(WDATA_IN[15:0]))
    else $error("frame sync width not written");
  // Line sync leaves active data directly only when the gap is zero
  sync_start_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    hs_rise ##0 !$past(wr_line) |-> $past(phase_r) != stcr_pkg::ST_ACTIVE || front_gap == 8'h00)
    else $error("line sync started without front gap");
  // Score selection with the override bit clear and set
  first_own_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !first_score_r[31] |-> FIRST_SCORE_OUT == OWN_FIRST_SCORE_IN)
    else $error("first score not own value");
  later_prog_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    later_score_r[31] |-> LATER_SCORE_OUT == later_score_r[12:0])
    else $error("later score override ignored");
  // Written values reach the outputs one cycle later
  div_write_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_div |=> TWO_WIRE_DIV_OUT == $past(WDATA_IN[7:0]))
    else $error("divisor not written");
  crc_count_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_crcc |=> CRC_CHANGE_COUNT_OUT == $past(WDATA_IN[3:0]))
    else $error("crc change count not written");
  crc_red_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_red |=> CRC_RED_OUT == $past(WDATA_IN))
    else $error("red crc not written");
  crc_green_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_green |=> CRC_GREEN_OUT == $past(WDATA_IN))
    else $error("green crc not written");
  crc_blue_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    wr_blue |=> CRC_BLUE_OUT == $past(WDATA_IN))
    else $error("blue crc not written");
  // Undefined control bits and the other payload view fields on reads
  ctrl_read_zero_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    bus.rd && bus.addr == stcr_pkg::OFS_CRC_CTRL |=> RDATA_OUT[31:6] == 26'h0000000 && !RDATA_OUT[4])
    else $error("crc control undefined bits not zero");
  payload_fields_a: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    bus.rd && bus.addr == stcr_pkg::OFS_PAYLOAD_VIEW |=>
    RDATA_OUT[5:0] == $past(PAYLOAD_TAG_IN) && RDATA_OUT[21:16] == $past(SLOT_COUNT_IN))
    else $error("payload tag or slot count wrong");
endmodule // stcr_regs
`default_nettype wire

// ==== rtl/stcr_pkg.sv ====
// Package for the sink timing and CRC configuration bank.
// Assumes one register-bus clock; offsets are byte addresses.
package stcr_pkg;
  // --------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------
  localparam logic [11:0] OFS_LINE_SYNC = 12'h050;
  localparam logic [11:0] OFS_FRAME_SYNC = 12'h058;
  localparam logic [11:0] OFS_TWO_WIRE_DIV = 12'h060;
  localparam logic [11:0] OFS_FIRST_SCORE = 12'h064;
  localparam logic [11:0] OFS_LATER_SCORE = 12'h068;
  localparam logic [11:0] OFS_PAYLOAD_VIEW = 12'h06C;
  localparam logic [11:0] OFS_CRC_CTRL = 12'h074;
  localparam logic [11:0] OFS_CRC_RED = 12'h078;
  localparam logic [11:0] OFS_CRC_GREEN = 12'h07C;
  localparam logic [11:0] OFS_CRC_BLUE = 12'h080;
  localparam logic [11:0] OFS_VIDEO_IDENT = 12'h084;
  localparam logic [11:0] OFS_AUDIO_IDENT = 12'h088;
  localparam logic [11:0] OFS_TIMING_CTRL = 12'h0C0;
  // --------------------------------------------------------------
  // Reset values and field positions
  // --------------------------------------------------------------
  localparam logic [15:0] RST_LINE_SYNC = 16'h0F0F;
  localparam logic [15:0] RST_FRAME_SYNC = 16'h003F;
  localparam logic [15:0] FRAME_SYNC_MIN = 16'h003F;
  localparam int OVERRIDE_BIT = 31;
  localparam int CRC_EN_BIT = 5;
  localparam logic [15:0] RST_ACTIVE_LEN = 16'h0780;
  localparam logic [15:0] RST_LINES = 16'h0438;
  localparam logic [7:0] RST_BACK_GAP = 8'h28;
  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } stcr_bus_s;
  // Timing generator phases within a line
  typedef enum logic [1:0] {ST_ACTIVE, ST_FRONT, ST_SYNC, ST_BACK} stcr_line_e;
endpackage : stcr_pkg

// ==== test/stcr_far_model.sv ====
// Far-side model: the remote source feeding scores and payload allocation.
// Assumes the bench pulses new_in, one cycle, to draw fresh values.
`timescale 1ns/10ps
`default_nettype none
module stcr_far_model (
  input wire logic clk_in,
  input wire logic new_in,
  output logic [14:0] own_first_out,
  output logic [12:0] own_later_out,
  output logic [5:0] tag_out,
  output logic [5:0] start_out,
  output logic [5:0] count_out
);
  // -----------------------------------------------------------
  // Capability values, redrawn on request
  // -----------------------------------------------------------
  initial begin
    {own_first_out, own_later_out} = '0;
    {tag_out, start_out, count_out} = '0;
  end
  always @(posedge clk_in) begin
    if (new_in) begin
      own_first_out <= 15'($urandom);
      own_later_out <= 13'($urandom);
      tag_out <= 6'($urandom);
      start_out <= 6'($urandom);
      count_out <= 6'($urandom);
    end
  end
endmodule // stcr_far_model
`default_nettype wire

// ==== test/sink_timing_crc_config_regs_tb.sv ====
// Bench for the timing and CRC configuration bank.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module sink_timing_crc_config_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic far_new = 1'b0;
  logic [31:0] rdata, cr, cg, cb, d;
  logic [14:0] own1, s1;
  logic [12:0] own2, s2;
  logic [5:0] tag, st, cnt;
  logic [7:0] div, fg, pw;
  logic [15:0] fw;
  logic [3:0] ccnt;
  logic cen, vid, aud, ls, fs, de;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  logic [11:0] ofs [12];
  logic [31:0] msk [12];
  logic [31:0] v [12];
  // -----------------------------------------------------------
  // Design, far side and clock
  // -----------------------------------------------------------
  stcr_regs i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .OWN_FIRST_SCORE_IN(own1),
    .OWN_LATER_SCORE_IN(own2), .PAYLOAD_TAG_IN(tag), .START_SLOT_IN(st),
    .SLOT_COUNT_IN(cnt), .FIRST_SCORE_OUT(s1), .LATER_SCORE_OUT(s2),
    .TWO_WIRE_DIV_OUT(div), .CRC_EN_OUT(cen), .CRC_CHANGE_COUNT_OUT(ccnt),
    .CRC_RED_OUT(cr), .CRC_GREEN_OUT(cg), .CRC_BLUE_OUT(cb), .VIDEO_IDENT_OUT(vid),
    .AUDIO_IDENT_OUT(aud), .LINE_SYNC_OUT(ls), .FRAME_SYNC_OUT(fs), .DATA_ENABLE_OUT(de));
  stcr_far_model i_far (.clk_in(clk), .new_in(far_new), .own_first_out(own1),
    .own_later_out(own2), .tag_out(tag), .start_out(st), .count_out(cnt));
  initial begin
    forever #5 clk = ~clk;
  end
  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] dv);
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] dv);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 dv = rdata;
  endtask
  function automatic logic pick(input int sel);
    return sel == 0 ? ls : (sel == 1 ? fs : de);
  endfunction
  function automatic logic [31:0] view();
    return {10'h0, cnt, 2'h0, st, 2'h0, tag};
  endfunction
  // A wait that runs out counts as a mismatch and ends the run
  task automatic ran_out();
    bad_count++;
    $display("Error at %0t: wait ran out", $time);
    conclude();
  endtask
  // Bounded wait for a timing output to reach a level
  task automatic wait_on(input int sel, input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
      if (k > 20000) ran_out();
    end while (pick(sel) !== lvl);
  endtask
  // Length of the next full high pulse
  task automatic high_len(input int sel, output int len);
    wait_on(sel, 1'b0);
    wait_on(sel, 1'b1);
    len = 0;
    while (pick(sel) === 1'b1 && len < 20000) begin
      len++;
      @(posedge clk);
      #1;
    end
    if (len >= 20000) ran_out();
  endtask
  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    void'($urandom(32'h79f6f006));
    ofs = '{stcr_pkg::OFS_LINE_SYNC, stcr_pkg::OFS_FRAME_SYNC, stcr_pkg::OFS_TWO_WIRE_DIV,
      stcr_pkg::OFS_FIRST_SCORE, stcr_pkg::OFS_LATER_SCORE, stcr_pkg::OFS_PAYLOAD_VIEW,
      stcr_pkg::OFS_CRC_CTRL, stcr_pkg::OFS_CRC_RED, stcr_pkg::OFS_CRC_GREEN,
      stcr_pkg::OFS_CRC_BLUE, stcr_pkg::OFS_VIDEO_IDENT, stcr_pkg::OFS_AUDIO_IDENT};
    msk = '{32'h0000FFFF, 32'h0000FFFF, 32'h000000FF, 32'h80007FFF, 32'h80001FFF, 32'h0,
      32'h0000002F, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1, 32'h1};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      far_new <= 1'b1;
      @(posedge clk);
      far_new <= 1'b0;
      // Reset contents first time round, then written contents
      for (int i = 0; i < 12 && p == 0; i++) begin
        rd_reg(ofs[i], d);
        chk(d, i == 0 ? 32'h0F0F : i == 1 ? 32'h3F : i == 5 ? view() : 32'h0);
      end
      for (int i = 0; i < 12; i++) begin
        v[i] = $urandom & msk[i];
        if (i == 1) v[i] = 32'h3F + ($urandom % 64);
        if (i == 3 || i == 4) v[i][31] = p[0];
        wr_reg(ofs[i], ($urandom & ~msk[i]) | v[i]);
      end
      wr_reg(12'h0FC, $urandom);
      rd_reg(12'h0FC, d);
      chk(d, 32'h0);
      for (int i = 0; i < 12; i++) begin
        rd_reg(ofs[i], d);
        chk(d, i == 5 ? view() : v[i]);
      end
      chk(32'(div), v[2]);
      chk(32'({cen, ccnt}), 32'({v[6][5], v[6][3:0]}));
      chk(cr, v[7]);
      chk(cg, v[8]);
      chk(cb, v[9]);
      chk(32'({vid, aud}), 32'({v[10][0], v[11][0]}));
      chk(32'(s1), 32'(p ? v[3][14:0] : own1));
      chk(32'(s2), 32'(p ? v[4][12:0] : own2));
    end
    // Short frames of 4 lines by 16 pixels, then sync shapes at the edges
    wr_reg(stcr_pkg::OFS_TIMING_CTRL, 32'h0004_0010);
    for (int t = 0; t < 3; t++) begin
      fg = t == 0 ? 8'h00 : t == 1 ? 8'h02 : 8'($urandom % 30);
      pw = t == 0 ? 8'h01 : t == 1 ? 8'hFF : 8'(1 + $urandom % 30);
      fw = t == 0 ? 16'h003F : 16'(16'h40 + $urandom % 60);
      wr_reg(stcr_pkg::OFS_LINE_SYNC, {16'h0, fg, pw});
      wr_reg(stcr_pkg::OFS_FRAME_SYNC, {16'h0, fw});
      high_len(1, n);
      high_len(1, n);
      chk(32'(n), 32'(fw));
      high_len(0, n);
      high_len(0, n);
      chk(32'(n), 32'(pw));
      wait_on(2, 1'b1);
      wait_on(2, 1'b0);
      n = 0;
      while (ls !== 1'b1 && n < 600) begin
        n++;
        @(posedge clk);
        #1;
      end
      if (n >= 600) ran_out();
      chk(32'(n), 32'(fg));
    end
    // Reset again in mid-run: the sync widths return to their defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(stcr_pkg::OFS_LINE_SYNC, d);
    chk(d, 32'h0F0F);
    rd_reg(stcr_pkg::OFS_FRAME_SYNC, d);
    chk(d, 32'h3F);
    conclude();
  end
endmodule // sink_timing_crc_config_regs_tb
`default_nettype wire
